// ### design/dms_burst_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dms_burst_if;
    logic [2:0] start_off;
    logic [1:0] burst_len;
    logic       interleave;
    logic [2:0] index;
    logic [2:0] offset;
    modport ctrl (output start_off, output burst_len, output interleave,
                  output index, input offset);
    modport gen  (input start_off, input burst_len, input interleave,
                  input index, output offset);
endinterface
`default_nettype wire

// ### design/dms_cfg.svh
`ifndef DMS_CFG_SVH
`define DMS_CFG_SVH

// bank-select codes for the load-setting command
`define DMS_SEL_OPER       2'h0
`define DMS_SEL_EXT        2'h1

// operating-setting field positions
`define DMS_BL_LSB         0
`define DMS_BT_BIT         3
`define DMS_LAT_LSB        4
`define DMS_MODE_LSB       7
`define DMS_LOOP_RESET_BIT 8

// burst length codes
`define DMS_BL_TWO         3'h1
`define DMS_BL_FOUR        3'h2
`define DMS_BL_EIGHT       3'h3

// read latency codes
`define DMS_LAT_TWO        3'h2
`define DMS_LAT_TWO_HALF   3'h6

// operating mode codes (bits 11..7)
`define DMS_MODE_NORMAL    5'h00
`define DMS_MODE_LOOP_RST  5'h02

// extended register bits
`define DMS_EXT_LOOP_DIS   0
`define DMS_EXT_DRIVE      1
`define DMS_EXT_ISO        2

// register reset values
`define DMS_OPER_RESET     12'h000
`define DMS_EXT_RESET      12'h000

// whole clocks of read latency counted in full clocks
`define DMS_LAT_WHOLE      2

`endif

// ### design/dms_mode_setting.sv
`timescale 1ns/10ps
`default_nettype none
`include "dms_cfg.svh"

module dms_mode_setting
    import dms_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        load_setting_command,
    input  wire logic        bank_select_low,
    input  wire logic        bank_select_high,
    input  wire logic [11:0] address,
    input  wire logic        read_command,
    input  wire logic        self_refresh_active,
    output logic [11:0]      operating_setting,
    output logic [11:0]      extended_function_setting,
    output logic             loop_reset_pulse,
    output logic             loop_enabled,
    output logic             drive_strength_reduced,
    output logic             module_isolation_enable,
    output logic             burst_setting_reserved,
    output logic             mode_reserved,
    output logic             half_clock_latency,
    output logic             read_data_valid,
    output logic [2:0]       read_column_offset,
    output logic             read_first
);
    import dms_pkg::*;

    dms_burst_if bif ();

    dms_order_gen u_order (
        .bif (bif)
    );

    // decode the burst-length code; reserved codes flag an error
    function automatic dms_len_t decode_len(input logic [2:0] code);
        unique case (code)
            `DMS_BL_TWO:   decode_len = DMS_LEN_TWO;
            `DMS_BL_FOUR:  decode_len = DMS_LEN_FOUR;
            `DMS_BL_EIGHT: decode_len = DMS_LEN_EIGHT;
            default:       decode_len = DMS_LEN_RSVD;
        endcase
    endfunction

    function automatic logic [2:0] len_last(input dms_len_t len);
        unique case (len)
            DMS_LEN_TWO:  len_last = 3'h1;
            DMS_LEN_FOUR: len_last = 3'h3;
            default:      len_last = 3'h7;
        endcase
    endfunction

    logic [11:0] oper_reg;
    logic [11:0] oper_next;
    logic [11:0] ext_reg;
    logic [11:0] ext_next;
    logic        lrst_reg;
    logic        lrst_next;
    logic [1:0]  sel;
    logic        load_oper;
    logic        load_ext;

    assign sel = {bank_select_high, bank_select_low};
    assign load_oper = load_setting_command && (sel == `DMS_SEL_OPER);
    assign load_ext  = load_setting_command && (sel == `DMS_SEL_EXT);

    always_comb begin
        oper_next = oper_reg;
        ext_next  = ext_reg;
        lrst_next = 1'b0;
        if (load_oper) begin
            oper_next = address;
            oper_next[`DMS_LOOP_RESET_BIT] = 1'b0;
            lrst_next = (address[11:7] == `DMS_MODE_LOOP_RST);
        end
        if (load_ext) begin
            ext_next = address;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oper_reg <= `DMS_OPER_RESET;
            ext_reg  <= `DMS_EXT_RESET;
            lrst_reg <= 1'b0;
        end else begin
            oper_reg <= oper_next;
            ext_reg  <= ext_next;
            lrst_reg <= lrst_next;
        end
    end

    dms_len_t   len;
    logic       interleaved;
    logic [2:0] lat_code;
    assign len         = decode_len(oper_reg[2:0]);
    assign interleaved = oper_reg[`DMS_BT_BIT];
    assign lat_code    = oper_reg[6:4];

    assign operating_setting         = oper_reg;
    assign extended_function_setting = ext_reg;
    assign loop_reset_pulse          = lrst_reg;
    // self refresh forces loop off, exit restores the programmed state
    assign loop_enabled = !ext_reg[`DMS_EXT_LOOP_DIS] && !self_refresh_active;
    assign drive_strength_reduced  = ext_reg[`DMS_EXT_DRIVE];
    assign module_isolation_enable = ext_reg[`DMS_EXT_ISO];
    assign burst_setting_reserved  = (len == DMS_LEN_RSVD);
    assign mode_reserved = (oper_reg[11:7] != `DMS_MODE_NORMAL);
    assign half_clock_latency = (lat_code == `DMS_LAT_TWO_HALF);

    // read sequencer: latency wait then one offset per transfer
    dms_state_t state_reg;
    dms_state_t state_next;
    logic [1:0] wait_reg;
    logic [1:0] wait_next;
    logic [2:0] idx_reg;
    logic [2:0] idx_next;
    logic [2:0] start_reg;
    logic [2:0] start_next;
    logic [2:0] col_reg;
    logic [2:0] col_next;
    logic       valid_reg;
    logic       valid_next;
    logic       first_reg;
    logic       first_next;

    assign bif.start_off  = start_reg;
    assign bif.burst_len  = len;
    assign bif.interleave = interleaved;
    assign bif.index      = idx_reg;

    always_comb begin
        state_next = state_reg;
        wait_next  = wait_reg;
        idx_next   = idx_reg;
        start_next = start_reg;
        col_next   = col_reg;
        valid_next = 1'b0;
        first_next = 1'b0;
        unique case (state_reg)
            DMS_IDLE: begin
                if (read_command && !burst_setting_reserved) begin
                    // start offset from low column bits
                    start_next = address[2:0] & len_last(len);
                    idx_next   = 3'h0;
                    // whole clocks; the half clock is an output phase
                    wait_next  = 2'(`DMS_LAT_WHOLE - 1);
                    state_next = DMS_WAIT;
                end
            end
            DMS_WAIT: begin
                if (wait_reg == 2'h1) begin
                    state_next = DMS_BURST;
                    col_next   = bif.offset;
                    valid_next = 1'b1;
                    first_next = 1'b1;
                    idx_next   = 3'h1;
                end else begin
                    wait_next = 2'(wait_reg + 2'h1);
                end
            end
            DMS_BURST: begin
                if (idx_reg > len_last(len)) begin
                    state_next = DMS_IDLE;
                end else begin
                    col_next   = bif.offset;
                    valid_next = 1'b1;
                    idx_next   = 3'(idx_reg + 3'h1);
                    if (idx_reg == len_last(len)) begin
                        state_next = DMS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= DMS_IDLE;
            wait_reg  <= 2'h0;
            idx_reg   <= 3'h0;
            start_reg <= 3'h0;
            col_reg   <= 3'h0;
            valid_reg <= 1'b0;
            first_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg  <= wait_next;
            idx_reg   <= idx_next;
            start_reg <= start_next;
            col_reg   <= col_next;
            valid_reg <= valid_next;
            first_reg <= first_next;
        end
    end

    assign read_data_valid    = valid_reg;
    assign read_column_offset = col_reg;
    assign read_first         = first_reg;

    // assertions
    a_oper_load: assert property (@(posedge clock)
        disable iff (!rst_n)
        load_oper |=> operating_setting ==
            ($past(address) & 12'heff))
        else $error("operating setting not loaded");
    a_ext_load: assert property (@(posedge clock)
        disable iff (!rst_n)
        load_ext |=> extended_function_setting == $past(address))
        else $error("extended setting not loaded");
    a_ext_hold: assert property (@(posedge clock)
        disable iff (!rst_n)
        !load_ext |=> $stable(extended_function_setting))
        else $error("extended setting changed without load");
    a_reset_clear: assert property (@(posedge clock)
        disable iff (!rst_n)
        !operating_setting[8])
        else $error("loop reset bit stuck");
    a_loop_pulse: assert property (@(posedge clock)
        disable iff (!rst_n)
        (load_oper && address[11:7] == 5'h02) |=> loop_reset_pulse)
        else $error("loop reset not started");
    a_read_lat: assert property (@(posedge clock)
        disable iff (!rst_n)
        (state_reg == DMS_IDLE && read_command && !burst_setting_reserved)
        |=> !read_data_valid ##1 (read_data_valid && read_first))
        else $error("first data not at latency");
    a_wrap_block: assert property (@(posedge clock)
        disable iff (!rst_n)
        read_data_valid |-> (read_column_offset & ~len_last(len)) == 3'h0)
        else $error("burst left its block");
    a_seq_order: assert property (@(posedge clock)
        disable iff (!rst_n)
        (read_data_valid && $past(read_data_valid) && !interleaved
         && !read_first && $stable(operating_setting))
        |-> read_column_offset ==
            ((3'($past(read_column_offset) + 3'h1)) & len_last(len)))
        else $error("sequential order wrong");
    a_ilv_first: assert property (@(posedge clock)
        disable iff (!rst_n)
        (read_data_valid && read_first) |-> read_column_offset == start_reg)
        else $error("first offset not start");
    a_selfref_off: assert property (@(posedge clock)
        disable iff (!rst_n)
        self_refresh_active |-> !loop_enabled)
        else $error("loop on in self refresh");
    // index register runs one ahead of the transfer being shown
    a_ilv_order: assert property (@(posedge clock)
        disable iff (!rst_n)
        (read_data_valid && interleaved && $stable(operating_setting))
        |-> read_column_offset ==
            ((start_reg ^ 3'(idx_reg - 3'h1)) & len_last(len)))
        else $error("interleaved order wrong");
    a_mode_flag: assert property (@(posedge clock)
        disable iff (!rst_n)
        (load_oper && (address[11:7] == `DMS_MODE_NORMAL
                       || address[11:7] == `DMS_MODE_LOOP_RST))
        |=> !mode_reserved)
        else $error("normal mode flagged reserved");
    a_half_flag: assert property (@(posedge clock)
        disable iff (!rst_n)
        (load_oper && address[6:4] == `DMS_LAT_TWO_HALF)
        |=> half_clock_latency)
        else $error("half clock latency not decoded");
    a_rsvd_refused: assert property (@(posedge clock)
        disable iff (!rst_n)
        (state_reg == DMS_IDLE && read_command && burst_setting_reserved)
        |=> (state_reg == DMS_IDLE && !read_data_valid))
        else $error("read accepted with reserved length");

    c_burst_eight: cover property (@(posedge clock) disable iff (!rst_n)
        read_first && len == DMS_LEN_EIGHT && interleaved);
    c_loop_reset: cover property (@(posedge clock) disable iff (!rst_n)
        loop_reset_pulse);
    c_ext_load: cover property (@(posedge clock) disable iff (!rst_n)
        load_ext ##1 module_isolation_enable);
    c_seq_wrap: cover property (@(posedge clock) disable iff (!rst_n)
        read_data_valid && !interleaved && !read_first
        && read_column_offset == 3'h0);
endmodule
`default_nettype wire

// ### design/dms_order_gen.sv
`timescale 1ns/10ps
`default_nettype none
module dms_order_gen
    import dms_pkg::*;
(
    dms_burst_if.gen bif
);
    import dms_pkg::*;

    function automatic logic [2:0] len_mask(input logic [1:0] len);
        unique case (len)
            DMS_LEN_TWO:  len_mask = 3'h1;
            DMS_LEN_FOUR: len_mask = 3'h3;
            default:      len_mask = 3'h7;
        endcase
    endfunction

    logic [2:0] mask;
    logic [2:0] raw;

    always_comb begin
        mask = len_mask(bif.burst_len);
        if (bif.interleave) begin
            raw = bif.start_off ^ bif.index;
        end else begin
            raw = 3'(bif.start_off + bif.index);
        end
        bif.offset = raw & mask;
    end
endmodule
`default_nettype wire

// ### design/dms_pkg.sv
package dms_pkg;
    typedef enum logic [1:0] {
        DMS_LEN_TWO   = 2'h0,
        DMS_LEN_FOUR  = 2'h1,
        DMS_LEN_EIGHT = 2'h2,
        DMS_LEN_RSVD  = 2'h3
    } dms_len_t;

    typedef enum logic [2:0] {
        DMS_IDLE  = 3'b001,
        DMS_WAIT  = 3'b010,
        DMS_BURST = 3'b100
    } dms_state_t;
endpackage

// ### verification/dms_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module dms_ctrl_model (
    input  wire logic        clock,
    output logic             load_setting_command,
    output logic             bank_select_low,
    output logic             bank_select_high,
    output logic [11:0]      address,
    output logic             read_command,
    output logic             self_refresh_active
);
    int lock_cnt = 0;
    int gap = 0;
    int stalls = 0;
    initial begin
        load_setting_command = 1'b0;
        read_command = 1'b0;
        self_refresh_active = 1'b0;
        {bank_select_high, bank_select_low} = 2'h3;
        address = 12'hfff;
    end
    always @(posedge clock) begin
        lock_cnt <= lock_cnt + 1;
        if (gap > 0) begin
            gap <= gap - 1;
        end
    end
    // hold commands until the last wait has run out
    task automatic issue(input logic ld, input logic [1:0] sel,
                         input logic [11:0] val);
        for (int k = 0; k < 20 && gap > 0; k++) begin
            @(negedge clock);
        end
        if (gap > 0) begin
            stalls++;
        end
        load_setting_command = ld;
        read_command = ~ld;
        {bank_select_high, bank_select_low} = sel;
        address = val;
        @(negedge clock);
        load_setting_command = 1'b0;
        read_command = 1'b0;
        // released pins flip so a stale value cannot pass for a held one
        {bank_select_high, bank_select_low} = ~sel;
        address = ~val;
    endtask
    // mode field is only normal or loop reset
    task automatic load(input logic [1:0] sel, input logic [11:0] val);
        logic [11:0] v;
        v = val;
        if (sel == 2'h0 && v[11:7] != 5'h02) begin
            v[11:7] = 5'h00;
        end
        issue(1'b1, sel, v);
        gap = 2;
        // lock wait restarts at every loop enable
        if ((sel == 2'h1 && !v[0]) || (sel == 2'h0 && v[8])) begin
            lock_cnt = 0;
        end
    endtask
    // reads wait 200 clocks for the loop to lock
    task automatic read(input logic [2:0] col);
        for (int k = 0; k < 300 && lock_cnt < 200; k++) begin
            @(negedge clock);
        end
        if (lock_cnt < 200) begin
            stalls++;
        end
        issue(1'b0, 2'h0, {9'h1a5, col});
    endtask
    task automatic sr_enter();
        self_refresh_active = 1'b1;
        @(negedge clock);
    endtask
    // exit re-enables the loop; 10 clocks before commands
    task automatic sr_exit();
        self_refresh_active = 1'b0;
        lock_cnt = 0;
        gap = 10;
    endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dms_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    wire logic load_setting_command, bank_select_low, bank_select_high;
    wire logic read_command, self_refresh_active;
    wire logic [11:0] address, operating_setting, extended_function_setting;
    wire logic loop_reset_pulse, loop_enabled, drive_strength_reduced;
    wire logic module_isolation_enable, burst_setting_reserved;
    wire logic mode_reserved, half_clock_latency, read_data_valid, read_first;
    wire logic [2:0] read_column_offset;
    int n_fail = 0;
    int samples_checked = 0;
    always #12.5 clock = ~clock;
    dms_ctrl_model ctl (.clock(clock),
        .load_setting_command(load_setting_command),
        .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
        .address(address), .read_command(read_command),
        .self_refresh_active(self_refresh_active));
    dms_mode_setting dut (.clock(clock), .rst_n(rst_n),
        .load_setting_command(load_setting_command),
        .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
        .address(address), .read_command(read_command),
        .self_refresh_active(self_refresh_active),
        .operating_setting(operating_setting),
        .extended_function_setting(extended_function_setting),
        .loop_reset_pulse(loop_reset_pulse), .loop_enabled(loop_enabled),
        .drive_strength_reduced(drive_strength_reduced),
        .module_isolation_enable(module_isolation_enable),
        .burst_setting_reserved(burst_setting_reserved),
        .mode_reserved(mode_reserved), .half_clock_latency(half_clock_latency),
        .read_data_valid(read_data_valid),
        .read_column_offset(read_column_offset), .read_first(read_first));
    task automatic chk(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {11'h0, exp}, {11'h0, got});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic t_reset();
        chk("oper", 12'h000, operating_setting);
        chk("ext", 12'h000, extended_function_setting);
        chk1("loop_en", 1'b1, loop_enabled);
        chk1("bl_rsvd", 1'b1, burst_setting_reserved);
    endtask
    task automatic t_oper();
        ctl.load(2'h0, 12'h132);
        chk("oper", 12'h032, operating_setting);
        chk1("pulse", 1'b1, loop_reset_pulse);
        chk1("mode_rsvd", 1'b0, mode_reserved);
        @(negedge clock);
        chk1("pulse", 1'b0, loop_reset_pulse);
        ctl.load(2'h2, 12'hfff);
        chk("oper", 12'h032, operating_setting);
        chk("ext", 12'h000, extended_function_setting);
        ctl.load(2'h0, 12'h022);
        chk("oper", 12'h022, operating_setting);
        chk1("pulse", 1'b0, loop_reset_pulse);
    endtask
    task automatic t_ext();
        ctl.load(2'h1, 12'h006);
        chk("ext", 12'h006, extended_function_setting);
        chk1("drive", 1'b1, drive_strength_reduced);
        chk1("iso", 1'b1, module_isolation_enable);
        ctl.load(2'h1, 12'h001);
        chk1("loop_en", 1'b0, loop_enabled);
        ctl.load(2'h0, 12'h022);
        chk("ext", 12'h001, extended_function_setting);
        ctl.load(2'h1, 12'h000);
        ctl.sr_enter();
        chk1("loop_en", 1'b0, loop_enabled);
        ctl.sr_exit();
        #1;
        chk1("loop_en", 1'b1, loop_enabled);
    endtask
    task automatic t_rsvd();
        ctl.load(2'h0, 12'h024);
        chk1("bl_rsvd", 1'b1, burst_setting_reserved);
        ctl.read(3'h1);
        repeat (10) begin
            @(negedge clock);
            chk1("valid", 1'b0, read_data_valid);
        end
    endtask
    task automatic t_burst(input logic il, input logic [2:0] blc,
                           input logic [2:0] lat);
        int len;
        logic [2:0] s;
        logic [2:0] e;
        len = 1 << blc;
        ctl.load(2'h0, {5'h00, lat, il, blc});
        chk1("half", lat == 3'h6, half_clock_latency);
        chk1("bl_rsvd", 1'b0, burst_setting_reserved);
        for (int c = 0; c < 8; c++) begin
            ctl.read(c[2:0]);
            chk1("valid_early", 1'b0, read_data_valid);
            for (int i = 0; i < len; i++) begin
                @(negedge clock);
                s = c[2:0] & 3'(len - 1);
                e = il ? (s ^ 3'(i)) : 3'((c + i) % len);
                chk1("valid", 1'b1, read_data_valid);
                chk1("first", i == 0, read_first);
                chk("offset", 12'(e), 12'(read_column_offset));
            end
            @(negedge clock);
            chk1("valid_end", 1'b0, read_data_valid);
        end
    endtask
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_oper();
        t_ext();
        t_rsvd();
        for (int b = 1; b < 4; b++) begin
            for (int t = 0; t < 4; t++) begin
                t_burst(t[0], b[2:0], t[1] ? 3'h6 : 3'h2);
            end
        end
        chk("model_stalls", 12'h000, 12'(ctl.stalls));
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("MISMATCH run_length expected done seen timeout");
        test_done();
    end
endmodule
`default_nettype wire
